// [hdl/blvw_map.svh]
// Purpose : Offsets, field positions and reset values of the link,
//           product-data and upstream window 0 register bank.
// Assumes : Included by the sequencer, translator and register bank files.
// Notes   : Definitions only.
`ifndef BLVW_MAP_SVH
`define BLVW_MAP_SVH

// ==========================================================
// Register offsets (dword index = byte offset / 4)
`define BLVW_OFS_LINK_CFG0      8'hcc
`define BLVW_OFS_LINK_TIMERS    8'hd0
`define BLVW_OFS_LINK_RECOV     8'hd4
`define BLVW_OFS_PD_CAP         8'hd8
`define BLVW_OFS_PD_WORD        8'hdc
`define BLVW_OFS_WIN0_TBASE     8'he0
`define BLVW_OFS_WIN0_SETUP     8'he4

// ==========================================================
// Writable bit masks
`define BLVW_WMASK_LINK_CFG0    32'hffff_1fff
`define BLVW_WMASK_LINK_TIMERS  32'hffff_03ff
`define BLVW_WMASK_LINK_RECOV   32'h007f_7fff
`define BLVW_WMASK_PD_CAP       32'h80fc_0000
`define BLVW_WMASK_ALL          32'hffff_ffff

// ==========================================================
// Reset values
`define BLVW_RST_LINK_CFG0      32'h0400_1060
`define BLVW_RST_LINK_TIMERS    32'h0400_0217
`define BLVW_RST_LINK_RECOV     32'h0019_0254
`define BLVW_RST_ZERO           32'h0000_0000

// ==========================================================
// Fixed capability fields
`define BLVW_CAP_ID_PD          8'h03
`define BLVW_CAP_NEXT_PTR       8'hf0
`define BLVW_PD_EE_OFFSET       8'h40

// ==========================================================
// Field positions
`define BLVW_PD_ADDR_LSB        18
`define BLVW_PD_ADDR_MSB        23
`define BLVW_PD_OP_BIT          31
`define BLVW_WIN_LSB            12
`define BLVW_WIN_ENABLE_BIT     31
`define BLVW_WIN_FULL_4K        20'hfffff

`endif

// [hdl/blvw_pkg.sv]
// Purpose : Types shared by the register bank and its helpers.
// Assumes : blvw_map.svh holds all numbers.
// Notes   : One-hot state codes written out.
package blvw_pkg;

    // ==========================================================
    // Product-data cycle sequencer states
    typedef enum logic [1:0] {
        BLVW_SEQ_IDLE = 2'b01,
        BLVW_SEQ_BUSY = 2'b10
    } blvw_seq_state_t;

    typedef logic [31:0] blvw_word_t;

endpackage : blvw_pkg

// [hdl/blvw_pd_seq.sv]
// Purpose : Runs one EEPROM read or write cycle for product data.
// Assumes : EEPROM port logic shares clk_sys_in; done is one pulse.
// Notes   : Request level holds until the done pulse.
`timescale 1ns/100ps
`include "blvw_map.svh"

module blvw_pd_seq
    import blvw_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        sys_rst_in,
    input  wire logic        ce_in,
    // Start from register bank
    input  wire logic        start_in,
    input  wire logic        write_in,
    input  wire logic [5:0]  pd_addr_in,
    input  wire logic [31:0] wdata_in,
    // EEPROM port
    output logic             ee_req_out,
    output logic             ee_we_out,
    output logic [7:0]       ee_addr_out,
    output logic [31:0]      ee_wdata_out,
    input  wire logic        ee_done_in,
    // Status
    output logic             busy_out
);

    blvw_seq_state_t state;

    // ==========================================================
    // Sequencer
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            state      <= BLVW_SEQ_IDLE;
            ee_req_out <= 1'b0;
        end else if (ce_in) begin
            unique case (state)
                BLVW_SEQ_IDLE: begin
                    if (start_in) begin
                        state      <= BLVW_SEQ_BUSY;
                        ee_req_out <= 1'b1;
                    end
                end
                BLVW_SEQ_BUSY: begin
                    if (ee_done_in) begin
                        state      <= BLVW_SEQ_IDLE;
                        ee_req_out <= 1'b0;
                    end
                end
                default: begin
                    state      <= BLVW_SEQ_IDLE;
                    ee_req_out <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Cycle parameters latched at start
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            ee_we_out    <= 1'b0;
            ee_addr_out  <= 8'h00;
            ee_wdata_out <= `BLVW_RST_ZERO;
        end else if (ce_in && start_in && state == BLVW_SEQ_IDLE) begin
            ee_we_out    <= write_in;
            // Product-data byte N sits past the EEPROM header
            ee_addr_out  <= {2'b00, pd_addr_in} + `BLVW_PD_EE_OFFSET;
            ee_wdata_out <= wdata_in;
        end
    end

    assign busy_out = (state == BLVW_SEQ_BUSY);

endmodule : blvw_pd_seq

// [hdl/blvw_xlate.sv]
// Purpose : Upstream window 0 address translation.
// Assumes : Window hit decode is done by the caller.
// Notes   : One cycle of latency; result held in a register.
`timescale 1ns/100ps
`include "blvw_map.svh"

module blvw_xlate
    import blvw_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        sys_rst_in,
    input  wire logic        ce_in,
    // Window setup
    input  wire logic [19:0] tbase_in,
    input  wire logic [18:0] size_mask_in,
    // Request
    input  wire logic        valid_in,
    input  wire logic [31:0] addr_in,
    // Result
    output logic             valid_out,
    output logic [31:0]      addr_out
);

    logic [19:0] sel;
    logic [31:0] next_addr;

    // Enabled upper bits come from the base, rest pass through
    always_comb begin
        sel = {1'b1, size_mask_in};
        if (addr_in[31:`BLVW_WIN_LSB] == 20'h00000) begin
            // Lowest 4K is never translated
            next_addr = addr_in;
        end else begin
            next_addr = {(addr_in[31:`BLVW_WIN_LSB] & ~sel)
                         | (tbase_in & sel),
                         addr_in[`BLVW_WIN_LSB-1:0]};
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            valid_out <= 1'b0;
            addr_out  <= `BLVW_RST_ZERO;
        end else if (ce_in) begin
            valid_out <= valid_in;
            if (valid_in) begin
                addr_out <= next_addr;
            end
        end
    end

endmodule : blvw_xlate

// [hdl/blvw_regs.sv]
// Purpose : Configuration registers for link tuning, the product
//           data capability and upstream window 0.
// Assumes : Configuration accesses arrive as one-cycle strobes on
//           clk_sys_in; EEPROM port and translator share the clock.
// Notes   : Read data appear one cycle after the read strobe.
`timescale 1ns/100ps
`include "blvw_map.svh"

module blvw_regs
    import blvw_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        clk_sys_in,
    input  wire logic        sys_rst_in,
    input  wire logic        ce_in,
    // Configuration access
    input  wire logic        cfg_wr_in,
    input  wire logic        cfg_rd_in,
    input  wire logic [7:0]  cfg_addr_in,
    input  wire logic [3:0]  cfg_be_in,
    input  wire logic [31:0] cfg_wdata_in,
    output logic [31:0]      cfg_rdata_out,
    output logic             cfg_rvalid_out,
    // Window 0 setup load (strap / serial load)
    input  wire logic        setup_load_in,
    input  wire logic [31:0] setup_value_in,
    // Link training controls
    output logic             hot_reset_en_out,
    output logic             loopback_en_out,
    output logic             crosslink_en_out,
    output logic             force_config_out,
    output logic             debug_sel_out,
    output logic [2:0]       lane_neg_tries_out,
    output logic [4:0]       ts1_count_out,
    output logic [15:0]      l1_entry_timer_out,
    output logic [9:0]       l0s_lifetime_out,
    output logic [15:0]      l1_lifetime_out,
    output logic [7:0]       clock_recovery_interval_out,
    output logic [6:0]       l0s_exit_latency_out,
    output logic [6:0]       l1_exit_latency_out,
    // EEPROM port
    output logic             ee_req_out,
    output logic             ee_we_out,
    output logic [7:0]       ee_addr_out,
    output logic [31:0]      ee_wdata_out,
    input  wire logic        ee_done_in,
    input  wire logic [31:0] ee_rdata_in,
    // Upstream window 0 translation
    input  wire logic        up_valid_in,
    input  wire logic [31:0] up_addr_in,
    output logic             up_valid_out,
    output logic [31:0]      up_addr_out
);

    // ==========================================================
    // Helpers

    // Byte-enable merge limited to writable bits
    function automatic blvw_word_t merge_be(
        input blvw_word_t old_v,
        input blvw_word_t new_v,
        input logic [3:0] be,
        input blvw_word_t wmask
    );
        blvw_word_t m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
        merge_be = (old_v & ~m) | (new_v & m);
    endfunction : merge_be

    function automatic logic hit(input logic [7:0] ofs);
        hit = (cfg_addr_in[7:2] == ofs[7:2]);
    endfunction : hit

    // ==========================================================
    // Storage
    blvw_word_t  link_training_config_0;
    blvw_word_t  link_lifetime_timers;
    blvw_word_t  link_recovery_latency;
    logic [5:0]  pd_addr;
    logic        product_data_op_flag;
    blvw_word_t  product_data_word;
    logic [19:0] win0_tbase;
    logic [1:0]  win0_addr_type;
    logic        win0_prefetch;
    logic [18:0] win0_size_mask;

    logic        pd_busy;
    logic        pd_start;
    logic        pd_done;
    logic        pd_op_wr;
    blvw_word_t  next_cap;
    blvw_word_t  rd_mux;
    blvw_word_t  setup_view;
    blvw_word_t  tbase_view;
    blvw_word_t  tbase_merged;
    logic [5:0]  next_pd_addr;

    assign pd_done = pd_busy && ee_done_in;

    // ==========================================================
    // Link tuning registers
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            link_training_config_0 <= `BLVW_RST_LINK_CFG0;
            link_lifetime_timers   <= `BLVW_RST_LINK_TIMERS;
            link_recovery_latency  <= `BLVW_RST_LINK_RECOV;
        end else if (ce_in && cfg_wr_in) begin
            if (hit(`BLVW_OFS_LINK_CFG0)) begin
                link_training_config_0 <= merge_be(
                    link_training_config_0, cfg_wdata_in, cfg_be_in,
                    `BLVW_WMASK_LINK_CFG0);
            end
            if (hit(`BLVW_OFS_LINK_TIMERS)) begin
                link_lifetime_timers <= merge_be(
                    link_lifetime_timers, cfg_wdata_in, cfg_be_in,
                    `BLVW_WMASK_LINK_TIMERS);
            end
            if (hit(`BLVW_OFS_LINK_RECOV)) begin
                link_recovery_latency <= merge_be(
                    link_recovery_latency, cfg_wdata_in, cfg_be_in,
                    `BLVW_WMASK_LINK_RECOV);
            end
        end
    end

    // ==========================================================
    // Link control outputs, straight from the registers
    assign hot_reset_en_out            = link_training_config_0[0];
    assign loopback_en_out             = link_training_config_0[1];
    assign crosslink_en_out            = link_training_config_0[2];
    assign force_config_out            = link_training_config_0[3];
    assign debug_sel_out               = link_training_config_0[4];
    assign lane_neg_tries_out          = link_training_config_0[7:5];
    assign ts1_count_out               = link_training_config_0[12:8];
    assign l1_entry_timer_out          = link_training_config_0[31:16];
    assign l0s_lifetime_out            = link_lifetime_timers[9:0];
    assign l1_lifetime_out             = link_lifetime_timers[31:16];
    assign clock_recovery_interval_out = link_recovery_latency[7:0];
    assign l0s_exit_latency_out        = link_recovery_latency[14:8];
    assign l1_exit_latency_out         = link_recovery_latency[22:16];

    // ==========================================================
    // Product-data capability
    // A start needs byte 3 written; new starts are ignored while busy
    // so the EEPROM never sees overlapping cycles.
    assign pd_start = ce_in && cfg_wr_in && cfg_be_in[3] && !pd_busy
                      && hit(`BLVW_OFS_PD_CAP);
    assign pd_op_wr = cfg_wdata_in[`BLVW_PD_OP_BIT];

    // New address must reach the sequencer in the starting write
    assign next_pd_addr = cfg_be_in[2]
                          ? cfg_wdata_in[`BLVW_PD_ADDR_MSB:`BLVW_PD_ADDR_LSB]
                          : pd_addr;

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            pd_addr <= 6'h00;
        end else if (ce_in && cfg_wr_in && cfg_be_in[2] && !pd_busy
                     && hit(`BLVW_OFS_PD_CAP)) begin
            pd_addr <= cfg_wdata_in[`BLVW_PD_ADDR_MSB:`BLVW_PD_ADDR_LSB];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            product_data_op_flag <= 1'b0;
        end else if (ce_in) begin
            if (pd_done) begin
                // Read ends at 1, write ends at 0
                product_data_op_flag <= ~ee_we_out;
            end else if (pd_start) begin
                product_data_op_flag <= pd_op_wr;
            end
        end
    end

    // Completion load wins over a same-cycle software write
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            product_data_word <= `BLVW_RST_ZERO;
        end else if (ce_in) begin
            if (pd_done && !ee_we_out) begin
                product_data_word <= ee_rdata_in;
            end else if (cfg_wr_in && hit(`BLVW_OFS_PD_WORD)) begin
                product_data_word <= merge_be(
                    product_data_word, cfg_wdata_in, cfg_be_in,
                    `BLVW_WMASK_ALL);
            end
        end
    end

    blvw_pd_seq u_pd_seq (
        .clk_sys_in   (clk_sys_in),
        .sys_rst_in   (sys_rst_in),
        .ce_in        (ce_in),
        .start_in     (pd_start),
        .write_in     (pd_op_wr),
        .pd_addr_in   (next_pd_addr),
        .wdata_in     (product_data_word),
        .ee_req_out   (ee_req_out),
        .ee_we_out    (ee_we_out),
        .ee_addr_out  (ee_addr_out),
        .ee_wdata_out (ee_wdata_out),
        .ee_done_in   (ee_done_in),
        .busy_out     (pd_busy)
    );

    // ==========================================================
    // Upstream window 0 setup (read-only to configuration writes)
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            win0_addr_type <= 2'b00;
            win0_prefetch  <= 1'b0;
            win0_size_mask <= 19'h00000;
        end else if (ce_in && setup_load_in) begin
            win0_addr_type <= setup_value_in[2:1];
            win0_prefetch  <= setup_value_in[3];
            win0_size_mask <= setup_value_in[30:`BLVW_WIN_LSB];
        end
    end

    // Window enable has no storage: it always reads 1
    always_comb begin
        setup_view = `BLVW_RST_ZERO;
        setup_view[0]   = 1'b0;
        setup_view[2:1] = win0_addr_type;
        setup_view[3]   = win0_prefetch;
        if (win0_size_mask == 19'h00000) begin
            setup_view[31:`BLVW_WIN_LSB] = `BLVW_WIN_FULL_4K;
        end else begin
            setup_view[31:`BLVW_WIN_LSB] = {1'b1, win0_size_mask};
        end
    end

    // ==========================================================
    // Upstream window 0 translated base
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            win0_tbase <= 20'h00000;
        end else if (ce_in && cfg_wr_in && hit(`BLVW_OFS_WIN0_TBASE)) begin
            win0_tbase <= tbase_merged[31:`BLVW_WIN_LSB];
        end
    end

    assign tbase_view = {win0_tbase, 12'h000};
    assign tbase_merged = merge_be(tbase_view, cfg_wdata_in, cfg_be_in,
                                   {1'b1, win0_size_mask, 12'h000});

    blvw_xlate u_xlate (
        .clk_sys_in   (clk_sys_in),
        .sys_rst_in   (sys_rst_in),
        .ce_in        (ce_in),
        .tbase_in     (win0_tbase),
        .size_mask_in (win0_size_mask),
        .valid_in     (up_valid_in),
        .addr_in      (up_addr_in),
        .valid_out    (up_valid_out),
        .addr_out     (up_addr_out)
    );

    // ==========================================================
    // Read path
    always_comb begin
        next_cap = `BLVW_RST_ZERO;
        next_cap[7:0]  = `BLVW_CAP_ID_PD;
        next_cap[15:8] = `BLVW_CAP_NEXT_PTR;
        next_cap[`BLVW_PD_ADDR_MSB:`BLVW_PD_ADDR_LSB] = pd_addr;
        next_cap[`BLVW_PD_OP_BIT] = product_data_op_flag;
    end

    always_comb begin
        rd_mux = `BLVW_RST_ZERO;
        if (hit(`BLVW_OFS_LINK_CFG0)) begin
            rd_mux = link_training_config_0;
        end else if (hit(`BLVW_OFS_LINK_TIMERS)) begin
            rd_mux = link_lifetime_timers;
        end else if (hit(`BLVW_OFS_LINK_RECOV)) begin
            rd_mux = link_recovery_latency;
        end else if (hit(`BLVW_OFS_PD_CAP)) begin
            rd_mux = next_cap;
        end else if (hit(`BLVW_OFS_PD_WORD)) begin
            rd_mux = product_data_word;
        end else if (hit(`BLVW_OFS_WIN0_TBASE)) begin
            rd_mux = tbase_view;
        end else if (hit(`BLVW_OFS_WIN0_SETUP)) begin
            rd_mux = setup_view;
        end
    end

    // Byte enables only shape writes; reads return the whole word
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            cfg_rdata_out  <= `BLVW_RST_ZERO;
            cfg_rvalid_out <= 1'b0;
        end else if (ce_in) begin
            cfg_rvalid_out <= cfg_rd_in;
            if (cfg_rd_in) begin
                cfg_rdata_out <= rd_mux;
            end
        end
    end

endmodule : blvw_regs

// [test/blvw_regs_checker.sv]
// Purpose: Port-level checks on blvw_regs.
// Assumes: One clock; ce_in qualifies every update.
// Notes  : Bound to the register bank after the module.
`timescale 1ns/100ps
module blvw_regs_checker
    import blvw_pkg::*;
(
    // Clock and control
    input wire logic        clk_sys_in,
    input wire logic        sys_rst_in,
    input wire logic        ce_in,
    // Configuration access
    input wire logic        cfg_wr_in,
    input wire logic        cfg_rd_in,
    input wire logic [7:0]  cfg_addr_in,
    input wire logic [3:0]  cfg_be_in,
    input wire logic [31:0] cfg_wdata_in,
    input wire logic [31:0] cfg_rdata_out,
    // EEPROM and translation
    input wire logic        ee_req_out,
    input wire logic        ee_we_out,
    input wire logic [7:0]  ee_addr_out,
    input wire logic        ee_done_in,
    input wire logic        up_valid_in,
    input wire logic [31:0] up_addr_in,
    input wire logic        up_valid_out,
    input wire logic [31:0] up_addr_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);

    // ==========================================================
    // Helpers
    // Idle only: a start while busy is dropped
    logic pd_go;
    logic rd_cap;
    assign pd_go = ce_in && cfg_wr_in && cfg_addr_in[7:2] == 6'h36 &&
                   cfg_be_in == 4'hf && !ee_req_out;
    assign rd_cap = ce_in && cfg_rd_in && cfg_addr_in[7:2] == 6'h36;

    // ==========================================================
    // Assertions
    a_pd_addr_offset: assert property (pd_go |=> ee_addr_out ==
        {2'b00, $past(cfg_wdata_in[23:18])} + 8'h40) else $error("bad ee addr");
    a_pd_cycle_kind: assert property (pd_go |=> ee_req_out &&
        ee_we_out == $past(cfg_wdata_in[31])) else $error("bad cycle kind");
    a_req_holds: assert property (ee_req_out && !ee_done_in |=> ee_req_out)
        else $error("request dropped early");
    a_req_ends: assert property (ee_req_out && ee_done_in && ce_in |=>
        !ee_req_out) else $error("request outlived done");
    a_cap_header: assert property (rd_cap |=>
        cfg_rdata_out[15:0] == 16'hf003) else $error("bad capability header");
    a_setup_fixed: assert property (ce_in && cfg_rd_in &&
        cfg_addr_in[7:2] == 6'h39 |=> cfg_rdata_out[31] && !cfg_rdata_out[0])
        else $error("bad setup fixed bits");
    a_up_valid: assert property (ce_in && up_valid_in |=> up_valid_out)
        else $error("translation valid missing");
    a_low_window: assert property (ce_in && up_valid_in &&
        up_addr_in[31:12] == 20'h0 |=> up_addr_out == $past(up_addr_in))
        else $error("low 4K address altered");
    a_offset_kept: assert property (ce_in && up_valid_in |=>
        up_addr_out[11:0] == $past(up_addr_in[11:0])) else $error("offset lost");

    c_pd_read: cover property (pd_go && !cfg_wdata_in[31]);
    c_pd_write: cover property (pd_go && cfg_wdata_in[31]);
    c_xlate: cover property (ce_in && up_valid_in && up_addr_in[31:12] != 0);
endmodule : blvw_regs_checker

bind blvw_regs blvw_regs_checker blvw_regs_checker_i (.clk_sys_in,
    .sys_rst_in, .ce_in, .cfg_wr_in, .cfg_rd_in, .cfg_addr_in, .cfg_be_in,
    .cfg_wdata_in, .cfg_rdata_out, .ee_req_out, .ee_we_out, .ee_addr_out,
    .ee_done_in, .up_valid_in, .up_addr_in, .up_valid_out, .up_addr_out);

// [test/tb_top.sv]
// Purpose: Self-checking bench for blvw_regs.
// Assumes: ce_in held high except for one frozen-write check; the bench plays the EEPROM port.
// Notes  : Inputs change by non-blocking assignment at rising edges.
`timescale 1ns/100ps
module tb_top;
    logic clk_sys_in = 1'b0, sys_rst_in = 1'b1, ce_in = 1'b1;
    logic cfg_wr_in = 1'b0, cfg_rd_in = 1'b0, setup_load_in = 1'b0;
    logic ee_done_in = 1'b0, up_valid_in = 1'b0;
    logic [7:0] cfg_addr_in = 8'h00;
    logic [3:0] cfg_be_in = 4'h0;
    logic [31:0] cfg_wdata_in = 0, setup_value_in = 0, ee_rdata_in = 0;
    logic [31:0] up_addr_in = 0, cfg_rdata_out, ee_wdata_out, up_addr_out;
    logic cfg_rvalid_out, hot_reset_en_out, loopback_en_out;
    logic crosslink_en_out, force_config_out, debug_sel_out, ee_req_out;
    logic ee_we_out, up_valid_out;
    logic [2:0] lane_neg_tries_out;
    logic [4:0] ts1_count_out;
    logic [15:0] l1_entry_timer_out, l1_lifetime_out;
    logic [9:0] l0s_lifetime_out;
    logic [7:0] clock_recovery_interval_out, ee_addr_out;
    logic [6:0] l0s_exit_latency_out, l1_exit_latency_out;
    logic [31:0] cc_v, d0_v, d4_v;
    int num_errors = 0, n_compared = 0, cycles = 0;

    blvw_regs blvw_regs_i (.clk_sys_in, .sys_rst_in, .ce_in, .cfg_wr_in,
        .cfg_rd_in, .cfg_addr_in, .cfg_be_in, .cfg_wdata_in, .cfg_rdata_out,
        .cfg_rvalid_out, .setup_load_in, .setup_value_in, .hot_reset_en_out,
        .loopback_en_out, .crosslink_en_out, .force_config_out,
        .debug_sel_out, .lane_neg_tries_out, .ts1_count_out,
        .l1_entry_timer_out, .l0s_lifetime_out, .l1_lifetime_out,
        .clock_recovery_interval_out, .l0s_exit_latency_out,
        .l1_exit_latency_out, .ee_req_out, .ee_we_out, .ee_addr_out,
        .ee_wdata_out, .ee_done_in, .ee_rdata_in, .up_valid_in, .up_addr_in,
        .up_valid_out, .up_addr_out);

    // Field outputs regrouped in register layout
    assign cc_v = {l1_entry_timer_out, 3'h0, ts1_count_out,
        lane_neg_tries_out, debug_sel_out, force_config_out,
        crosslink_en_out, loopback_en_out, hot_reset_en_out};
    assign d0_v = {l1_lifetime_out, 6'h0, l0s_lifetime_out};
    assign d4_v = {9'h0, l1_exit_latency_out, 1'b0, l0s_exit_latency_out,
        clock_recovery_interval_out};

    initial begin
        forever #4 clk_sys_in = ~clk_sys_in;
    end

    // ==========================================================
    // Tasks
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic cfg_write(input logic [7:0] a, input logic [3:0] be,
                             input logic [31:0] d);
        @(posedge clk_sys_in);
        cfg_wr_in <= 1'b1;
        cfg_addr_in <= a;
        cfg_be_in <= be;
        cfg_wdata_in <= d;
        @(posedge clk_sys_in);
        cfg_wr_in <= 1'b0;
        #1;
    endtask : cfg_write

    task automatic cfg_check(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys_in);
        cfg_rd_in <= 1'b1;
        cfg_addr_in <= a;
        @(posedge clk_sys_in);
        cfg_rd_in <= 1'b0;
        #1;
        chk("read valid", {31'h0, cfg_rvalid_out}, 32'h1);
        chk($sformatf("register %h", a), cfg_rdata_out, exp);
    endtask : cfg_check

    task automatic pd_cycle(input logic [31:0] cmd, input logic [7:0] ea,
                            input logic [31:0] d);
        logic [31:0] cap;
        cap = {cmd[31], 7'h0, cmd[23:18], 2'b00, 16'hf003};
        cfg_write(8'hd8, 4'hf, cmd);
        @(posedge clk_sys_in);
        #1;
        chk("ee_req", {31'h0, ee_req_out}, 32'h1);
        chk("ee_addr", {24'h0, ee_addr_out}, {24'h0, ea});
        if (cmd[31]) chk("ee_wdata", ee_wdata_out, d);
        cfg_check(8'hd8, cap);
        // Second start while busy must not disturb the cycle
        cfg_write(8'hd8, 4'hf, ~cmd);
        chk("ee_we", {31'h0, ee_we_out}, {31'h0, cmd[31]});
        @(posedge clk_sys_in);
        ee_done_in <= 1'b1;
        ee_rdata_in <= d;
        @(posedge clk_sys_in);
        ee_done_in <= 1'b0;
        cfg_check(8'hd8, cap ^ 32'h8000_0000);
        chk("ee_req idle", {31'h0, ee_req_out}, 32'h0);
    endtask : pd_cycle

    task automatic xlate(input logic [31:0] a, input logic [31:0] exp);
        @(posedge clk_sys_in);
        up_valid_in <= 1'b1;
        up_addr_in <= a;
        @(posedge clk_sys_in);
        up_valid_in <= 1'b0;
        #1;
        chk("up_valid", {31'h0, up_valid_out}, 32'h1);
        chk("up_addr", up_addr_out, exp);
    endtask : xlate

    task automatic complete_run();
        $display("Compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run

    // ==========================================================
    // Sequence
    initial begin
        repeat (12) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        #1;
        chk("link0 fields", cc_v, 32'h0400_1060);
        chk("link2 fields", d4_v, 32'h0019_0254);
        cfg_check(8'hcc, 32'h0400_1060);
        cfg_check(8'hd0, 32'h0400_0217);
        cfg_check(8'hd4, 32'h0019_0254);
        cfg_check(8'hd8, 32'h0000_f003);
        cfg_check(8'hdc, 32'h0000_0000);
        cfg_check(8'he0, 32'h0000_0000);
        cfg_check(8'he4, 32'hffff_f000);
        cfg_check(8'hc0, 32'h0000_0000);
        cfg_write(8'hcc, 4'hf, 32'hffff_ffff);
        chk("link0 fields", cc_v, 32'hffff_1fff);
        cfg_write(8'hcc, 4'h1, 32'h0);
        cfg_check(8'hcc, 32'hffff_1f00);
        cfg_write(8'hd4, 4'hf, 32'hffff_ffff);
        chk("link2 fields", d4_v, 32'h007f_7fff);
        // Clock enable low: a write must leave the register alone
        @(posedge clk_sys_in);
        ce_in <= 1'b0;
        cfg_write(8'hd4, 4'hf, 32'h0);
        @(posedge clk_sys_in);
        ce_in <= 1'b1;
        #1;
        chk("frozen fields", d4_v, 32'h007f_7fff);
        cfg_write(8'hd0, 4'hf, 32'hffff_ffff);
        chk("link1 fields", d0_v, 32'hffff_03ff);
        cfg_write(8'hdc, 4'hf, 32'h1122_3344);
        cfg_write(8'hdc, 4'h4, 32'haaaa_aaaa);
        cfg_check(8'hdc, 32'h11aa_3344);
        pd_cycle(32'h00fc_0000, 8'h7f, 32'h5a5a_0102);
        cfg_check(8'hdc, 32'h5a5a_0102);
        pd_cycle(32'h8004_0000, 8'h41, 32'h5a5a_0102);
        cfg_write(8'he0, 4'hf, 32'hffff_ffff);
        cfg_check(8'he0, 32'h8000_0000);
        @(posedge clk_sys_in);
        setup_load_in <= 1'b1;
        setup_value_in <= 32'h7fff_000a;
        @(posedge clk_sys_in);
        setup_load_in <= 1'b0;
        cfg_write(8'he4, 4'hf, 32'h0);
        cfg_check(8'he4, 32'hffff_000a);
        cfg_write(8'he0, 4'hf, 32'habcd_e000);
        cfg_check(8'he0, 32'habcd_0000);
        xlate(32'h1234_5678, 32'habcd_5678);
        xlate(32'h0000_0abc, 32'h0000_0abc);
        complete_run();
    end

    // Hang guard: the full sequence needs about 90 cycles
    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            complete_run();
        end
    end
endmodule : tb_top
